// ---- verilog/charger_monitor_pkg.sv ----
// Purpose: Shared constants and types for the charger monitor result bank
// Assumes: 8-bit byte-addressed register space reached over a two-wire serial port
// Notes:   Engineering units are mV for voltages and power, mA for currents
package charger_monitor_pkg;

  // Byte addresses
  localparam logic [7:0] REG_LIMIT_LOW  = 8'h24;
  localparam logic [7:0] REG_SYS_POWER  = 8'h26;
  localparam logic [7:0] REG_BUS_VOLT   = 8'h27;
  localparam logic [7:0] REG_DSCH_CURR  = 8'h28;
  localparam logic [7:0] REG_CHG_CURR   = 8'h29;
  localparam logic [7:0] REG_CMP_INPUT  = 8'h2A;
  localparam logic [7:0] REG_IN_CURR    = 8'h2B;
  localparam logic [7:0] REG_BATT_VOLT  = 8'h2C;
  localparam logic [7:0] REG_SYS_VOLT   = 8'h2D;
  localparam logic [7:0] REG_OPT_LOW    = 8'h30;
  localparam logic [7:0] REG_OPT_HIGH   = 8'h31;

  // Reset values
  localparam logic [7:0] RST_LIMIT_LOW  = 8'h00;
  localparam logic [7:0] RST_OPT_LOW    = 8'h00;
  localparam logic [7:0] RST_OPT_HIGH   = 8'h3F;
  localparam logic [7:0] RST_RESULT     = 8'h00;

  // Result slot indices, slot = address - REG_SYS_POWER
  localparam int NUM_RESULTS = 8;
  localparam int IDX_SYS_POWER = 0;
  localparam int IDX_BUS_VOLT  = 1;
  localparam int IDX_DSCH_CURR = 2;
  localparam int IDX_CHG_CURR  = 3;
  localparam int IDX_CMP_INPUT = 4;
  localparam int IDX_IN_CURR   = 5;
  localparam int IDX_BATT_VOLT = 6;
  localparam int IDX_SYS_VOLT  = 7;

  // Weights per count and zero-code offsets
  localparam logic [9:0]  LSB_RANGE_HI_MV  = 10'd12;
  localparam logic [9:0]  LSB_RANGE_LO_MV  = 10'd8;
  localparam logic [9:0]  LSB_BUS_MV       = 10'd96;
  localparam logic [9:0]  LSB_CHG_10M_MA   = 10'd64;
  localparam logic [9:0]  LSB_CHG_5M_MA    = 10'd128;
  localparam logic [9:0]  LSB_DSCH_10M_MA  = 10'd256;
  localparam logic [9:0]  LSB_DSCH_5M_MA   = 10'd512;
  localparam logic [9:0]  LSB_IN_10M_MA    = 10'd50;
  localparam logic [9:0]  LSB_IN_5M_MA     = 10'd100;
  localparam logic [9:0]  LSB_CELL_MV      = 10'd64;
  localparam logic [15:0] OFS_LOW_CELL_MV  = 16'd2880;
  localparam logic [15:0] OFS_FIVE_CELL_MV = 16'd8160;
  localparam logic [15:0] OFS_NONE         = 16'd0;

  // Seven-bit current results clip here
  localparam logic [7:0] CURR_CODE_MAX = 8'h7F;

  // Power monitor configuration codes
  localparam logic [1:0] PMON_BUS_BATT = 2'b00;
  localparam logic [1:0] PMON_BUS_ONLY = 2'b01;
  localparam logic [1:0] PMON_RESERVED = 2'b10;
  localparam logic [1:0] PMON_OFF      = 2'b11;

  localparam logic [2:0] BIT_LAST = 3'd7;

  typedef struct packed {
    logic       batt_current_buffer_en;
    logic       lowpower_hot_signal_en;
    logic [1:0] power_monitor_config;
    logic       input_sense_select;
    logic       charge_sense_select;
    logic       power_monitor_gain;
    logic       reserved_bit;
  } opt_high_t;

  // Raw codes from the analog monitor, one per result slot
  typedef struct packed {
    logic [7:0] sys_volt;
    logic [7:0] batt_volt;
    logic [7:0] in_curr;
    logic [7:0] cmp_input;
    logic [7:0] chg_curr;
    logic [7:0] dsch_curr;
    logic [7:0] bus_volt;
    logic [7:0] sys_power;
  } monitor_sample_t;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0011,
    ST_PTR       = 4'b0010,
    ST_PTR_ACK   = 4'b0110,
    ST_WDATA     = 4'b0111,
    ST_WDATA_ACK = 4'b0101,
    ST_RDATA     = 4'b0100,
    ST_RDATA_ACK = 4'b1100
  } serial_state_t;

endpackage : charger_monitor_pkg

// ---- verilog/line_edge_detect.sv ----
// Purpose: Registered copy and edge pulses of a synchronous serial line
// Assumes: Input already synchronous to sys_clk
// Notes:   Pulses are one cycle wide, one cycle after the line moves
`timescale 1ns/1ps
module line_edge_detect
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Line
  input  wire logic line_in,
  output logic      line_ff,
  output logic      rise,
  output logic      fall
);
  logic prev_ff;

  // Lines idle high on an open-drain bus
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_ff <= 1'b1;
      prev_ff <= 1'b1;
    end
    else
    begin
      line_ff <= line_in;
      prev_ff <= line_ff;
    end
  end

  assign rise = line_ff & ~prev_ff;
  assign fall = ~line_ff & prev_ff;

endmodule : line_edge_detect

// ---- verilog/result_scaler.sv ----
// Purpose: Convert one monitor code to engineering units
// Assumes: Weight and offset chosen by the caller from the range selects
// Notes:   16-bit result covers every documented full-scale value
`timescale 1ns/1ps
module result_scaler
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Scaling inputs
  input  wire logic [7:0]  code,
  input  wire logic [9:0]  lsb,
  input  wire logic [15:0] offset,
  // Result
  output logic      [15:0] value_ff
);
  logic [17:0] nxt_value;

  assign nxt_value = 18'(offset) + 18'(code) * 18'(lsb);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      value_ff <= 16'h0000;
    else
      value_ff <= nxt_value[15:0];
  end

  AST_SCALE_VALUE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    1'b1 |=> value_ff == 16'($past(offset) + $past(code) * $past(lsb)))
    else $error("scaled value does not match code times weight");

endmodule : result_scaler

// ---- verilog/charger_monitor_regs.sv ----
// Purpose: Monitor result bytes and option bytes behind a two-wire serial port
// Assumes: Serial lines synchronous to sys_clk and well slower than it
// Notes:   Pointer advances after each written or acknowledged read byte
// Functional notes
// R1: Power result 12 or 8 mV by range
// R2: Bus voltage 96 mV per count
// R3: Bus voltage 0x27, power 0x26, read-only
// R4: Charge current 64 or 128 mA
// R5: Discharge 256/512 mA, saturating
// R6: Current results seven bits, bit 7 zero; only charge and discharge are clipped, input current keeps eight bits
// R7: Input current 50 or 100 mA
// R8: Comparator input 12 or 8 mV by range
// R9: Input current 0x2B, comparator 0x2A, read-only
// R10: One-four cells: 64 mV from 2.88 V
// R11: Five cells: 64 mV from 8.16 V
// R12: System voltage 0x2D, battery 0x2C, read-only
// R13: Bit 7 enables battery current buffer
// R14: Bit 6 enables battery-only hot signalling
// R15: Bits 5:4 select power monitor mode
// R16: Low power forces power monitor off
// R17: Bit 3 selects input sense resistor
// R18: Bit 2 selects charge sense resistor
// R19: Bit 1 selects power monitor gain
// R20: Byte 0x24 reads as zero
// R21: Byte 0x30 bit 7 selects comparator reference
// R22: Reads side-effect free, result writes ignored
// R23: Bit 0 reserved read-write, resets one
`timescale 1ns/1ps
module charger_monitor_regs
  import charger_monitor_pkg::*;
#(
  // Arbitrary bus address, not tied to any part
  parameter logic [6:0] DEV_ADDR = 7'h2A
)
(
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Serial port, open drain data
  input  wire logic             scl_in,
  input  wire logic             sda_in,
  output logic                  sda_out,
  output logic                  sda_oe,
  // Analog monitor side
  input  wire logic             conv_valid,
  input  wire monitor_sample_t  conv_sample,
  input  wire logic             monitor_range_select,
  input  wire logic             five_cell,
  // Operating status
  input  wire logic             low_power_mode,
  input  wire logic             adapter_present,
  // Controls to the analog blocks
  output logic                  batt_current_buffer_en,
  output logic                  lowpower_hot_signal_en,
  output logic                  power_monitor_en,
  output logic      [1:0]       power_monitor_config,
  output logic                  power_monitor_gain,
  output logic                  input_sense_select,
  output logic                  charge_sense_select,
  output logic                  comparator_reference_select,
  output logic      [7:0]       option_low,
  // Results in mV or mA
  output logic [NUM_RESULTS-1:0][15:0] eng_value
);

  serial_state_t state_ff;
  serial_state_t nxt_state;
  logic [7:0]    shift_ff;
  logic [2:0]    bit_cnt_ff;
  logic          byte_done_ff;
  logic          read_mode_ff;
  logic          master_ack_ff;
  logic [7:0]    ptr_ff;
  logic          sda_oe_ff;
  logic          sda_out_ff;
  logic [7:0]    result_ff [NUM_RESULTS];
  logic [7:0]    opt_low_ff;
  opt_high_t     opt_high_ff;
  logic          buf_en_ff;
  logic          hot_en_ff;
  logic          pmon_en_ff;
  logic [1:0]    pmon_cfg_ff;

  logic scl_ff;
  logic scl_rise;
  logic scl_fall;
  logic sda_ff;
  logic sda_rise;
  logic sda_fall;

  line_edge_detect u_scl_edge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .line_in (scl_in),
    .line_ff (scl_ff),
    .rise    (scl_rise),
    .fall    (scl_fall)
  );

  line_edge_detect u_sda_edge (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .line_in (sda_in),
    .line_ff (sda_ff),
    .rise    (sda_rise),
    .fall    (sda_fall)
  );

  // Byte read from the bank; unmapped and reserved bytes read zero
  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    logic [7:0] idx;
    idx = addr - REG_SYS_POWER;
    if (addr == REG_LIMIT_LOW)
      read_byte = RST_LIMIT_LOW;                               // [R20]
    else if (addr >= REG_SYS_POWER && addr <= REG_SYS_VOLT)
      read_byte = result_ff[idx[2:0]];                         // [R3] [R9] [R12]
    else if (addr == REG_OPT_LOW)
      read_byte = opt_low_ff;
    else if (addr == REG_OPT_HIGH)
      read_byte = opt_high_ff;
    else
      read_byte = 8'h00;
  endfunction : read_byte

  // Clip a raw current code into the seven-bit field
  function automatic logic [7:0] clip_current(input logic [7:0] raw);
    clip_current = (raw > CURR_CODE_MAX) ? CURR_CODE_MAX : raw; // [R5] [R6]
  endfunction : clip_current

  wire logic start_seen = sda_fall & scl_ff;
  wire logic stop_seen  = sda_rise & scl_ff;
  wire logic addr_match = (shift_ff[7:1] == DEV_ADDR);
  // Next byte is already addressed while the master acknowledges
  wire logic [7:0] rd_ptr = (state_ff == ST_RDATA_ACK) ? ptr_ff + 8'h01 : ptr_ff;
  logic [7:0] rd_byte;
  // A process, so result and option updates re-evaluate the read byte
  always_comb rd_byte = read_byte(rd_ptr);
  wire logic wr_strobe = (state_ff == ST_WDATA) & byte_done_ff & scl_fall;
  wire logic in_byte_state = (state_ff == ST_ADDR) | (state_ff == ST_PTR)
                           | (state_ff == ST_WDATA);

  // Next state, moved on the clock falling edge so data changes while it is low
  always_comb
  begin
    nxt_state = state_ff;
    if (stop_seen)
      nxt_state = ST_IDLE;
    else if (start_seen)
      nxt_state = ST_ADDR;
    else if (scl_fall)
    begin
      case (state_ff)
        ST_ADDR:      if (byte_done_ff) nxt_state = addr_match ? ST_ADDR_ACK : ST_IDLE;
        ST_ADDR_ACK:  nxt_state = read_mode_ff ? ST_RDATA : ST_PTR;
        ST_PTR:       if (byte_done_ff) nxt_state = ST_PTR_ACK;
        ST_PTR_ACK:   nxt_state = ST_WDATA;
        ST_WDATA:     if (byte_done_ff) nxt_state = ST_WDATA_ACK;
        ST_WDATA_ACK: nxt_state = ST_WDATA;
        ST_RDATA:     if (bit_cnt_ff == BIT_LAST) nxt_state = ST_RDATA_ACK;
        ST_RDATA_ACK: nxt_state = master_ack_ff ? ST_RDATA : ST_IDLE;
        default:      nxt_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Bit counter and shifter
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_ff     <= 8'h00;
      bit_cnt_ff   <= 3'd0;
      byte_done_ff <= 1'b0;
    end
    else if (start_seen || nxt_state != state_ff)
    begin
      bit_cnt_ff   <= 3'd0;
      byte_done_ff <= 1'b0;
      if (nxt_state == ST_RDATA)
        shift_ff <= rd_byte;
    end
    else if (scl_rise && in_byte_state)
    begin
      shift_ff     <= {shift_ff[6:0], sda_ff};
      bit_cnt_ff   <= bit_cnt_ff + 3'd1;
      byte_done_ff <= (bit_cnt_ff == BIT_LAST);
    end
    else if (scl_fall && state_ff == ST_RDATA)
    begin
      shift_ff   <= {shift_ff[6:0], 1'b0};
      bit_cnt_ff <= bit_cnt_ff + 3'd1;
    end
  end

  // Direction bit and the master's acknowledge of each read byte
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      read_mode_ff  <= 1'b0;
      master_ack_ff <= 1'b0;
    end
    else
    begin
      if (state_ff == ST_ADDR && byte_done_ff)
        read_mode_ff <= shift_ff[0];
      if (state_ff == ST_RDATA_ACK && scl_rise)
        master_ack_ff <= ~sda_ff;
    end
  end

  // Pointer advances after each written or acknowledged read byte
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_ff <= 8'h00;
    else if (state_ff == ST_PTR && byte_done_ff && scl_fall)
      ptr_ff <= shift_ff;
    else if (wr_strobe || (state_ff == ST_RDATA_ACK && scl_fall && master_ack_ff))
      ptr_ff <= ptr_ff + 8'h01;
  end

  // Data line: low for our acknowledges and for zero bits we send
  wire logic nxt_oe = (nxt_state == ST_ADDR_ACK) | (nxt_state == ST_PTR_ACK)
                    | (nxt_state == ST_WDATA_ACK);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sda_oe_ff  <= 1'b0;
      sda_out_ff <= 1'b0;
    end
    else if (nxt_state == ST_RDATA)
      sda_oe_ff <= (nxt_state != state_ff) ? ~rd_byte[7]
                 : (scl_fall ? ~shift_ff[6] : sda_oe_ff);
    else
      sda_oe_ff <= nxt_oe;
  end

  assign sda_out = sda_out_ff;
  assign sda_oe  = sda_oe_ff;

  // Results refresh only from the monitor; serial writes never reach them
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_RESULTS; i++)
        result_ff[i] <= RST_RESULT;
    end
    else if (conv_valid)
    begin
      result_ff[IDX_SYS_POWER] <= conv_sample.sys_power;
      result_ff[IDX_BUS_VOLT]  <= conv_sample.bus_volt;
      result_ff[IDX_DSCH_CURR] <= clip_current(conv_sample.dsch_curr); // [R5] [R6]
      result_ff[IDX_CHG_CURR]  <= clip_current(conv_sample.chg_curr);  // [R6]
      result_ff[IDX_CMP_INPUT] <= conv_sample.cmp_input;
      result_ff[IDX_IN_CURR]   <= conv_sample.in_curr;
      result_ff[IDX_BATT_VOLT] <= conv_sample.batt_volt;
      result_ff[IDX_SYS_VOLT]  <= conv_sample.sys_volt;
    end
  end

  // Option bytes; only these two addresses accept writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opt_low_ff  <= RST_OPT_LOW;
      opt_high_ff <= RST_OPT_HIGH;                               // [R23]
    end
    else if (wr_strobe)
    begin
      if (ptr_ff == REG_OPT_LOW)
        opt_low_ff <= shift_ff;                                  // [R21]
      else if (ptr_ff == REG_OPT_HIGH)
        opt_high_ff <= shift_ff;                                 // [R22]
    end
  end

  // Low power overrides the buffer and monitor enables
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_en_ff   <= 1'b0;
      hot_en_ff   <= 1'b0;
      pmon_en_ff  <= 1'b0;
      pmon_cfg_ff <= PMON_OFF;
    end
    else
    begin
      buf_en_ff   <= opt_high_ff.batt_current_buffer_en & ~low_power_mode;  // [R13]
      // Battery-only function; held off with an adapter present
      hot_en_ff   <= opt_high_ff.lowpower_hot_signal_en & ~adapter_present; // [R14]
      pmon_en_ff  <= ~low_power_mode                                        // [R16]
                   & (opt_high_ff.power_monitor_config != PMON_OFF)         // [R15]
                   & (opt_high_ff.power_monitor_config != PMON_RESERVED);
      pmon_cfg_ff <= opt_high_ff.power_monitor_config;                      // [R15]
    end
  end

  assign batt_current_buffer_en      = buf_en_ff;
  assign lowpower_hot_signal_en      = hot_en_ff;
  assign power_monitor_en            = pmon_en_ff;
  assign power_monitor_config        = pmon_cfg_ff;
  assign power_monitor_gain          = opt_high_ff.power_monitor_gain;        // [R19]
  assign input_sense_select          = opt_high_ff.input_sense_select;        // [R17]
  assign charge_sense_select         = opt_high_ff.charge_sense_select;       // [R18]
  assign comparator_reference_select = opt_low_ff[7];                         // [R21]
  assign option_low                  = opt_low_ff;

  // Weight and offset per slot from the range and sense selects
  wire logic [9:0] range_lsb = monitor_range_select ? LSB_RANGE_HI_MV : LSB_RANGE_LO_MV;
  wire logic [15:0] cell_ofs = five_cell ? OFS_FIVE_CELL_MV : OFS_LOW_CELL_MV; // [R10] [R11]
  logic [NUM_RESULTS-1:0][9:0]  slot_lsb;
  logic [NUM_RESULTS-1:0][15:0] slot_ofs;

  assign slot_lsb[IDX_SYS_POWER] = range_lsb;                                      // [R1]
  assign slot_lsb[IDX_BUS_VOLT]  = LSB_BUS_MV;                                     // [R2]
  assign slot_lsb[IDX_DSCH_CURR] = opt_high_ff.charge_sense_select ? LSB_DSCH_5M_MA
                                                                   : LSB_DSCH_10M_MA; // [R5]
  assign slot_lsb[IDX_CHG_CURR]  = opt_high_ff.charge_sense_select ? LSB_CHG_5M_MA
                                                                   : LSB_CHG_10M_MA;  // [R4]
  assign slot_lsb[IDX_CMP_INPUT] = range_lsb;                                      // [R8]
  assign slot_lsb[IDX_IN_CURR]   = opt_high_ff.input_sense_select ? LSB_IN_5M_MA
                                                                  : LSB_IN_10M_MA;    // [R7]
  assign slot_lsb[IDX_BATT_VOLT] = LSB_CELL_MV;
  assign slot_lsb[IDX_SYS_VOLT]  = LSB_CELL_MV;
  assign slot_ofs[IDX_SYS_POWER] = OFS_NONE;
  assign slot_ofs[IDX_BUS_VOLT]  = OFS_NONE;
  assign slot_ofs[IDX_DSCH_CURR] = OFS_NONE;
  assign slot_ofs[IDX_CHG_CURR]  = OFS_NONE;
  assign slot_ofs[IDX_CMP_INPUT] = OFS_NONE;
  assign slot_ofs[IDX_IN_CURR]   = OFS_NONE;
  assign slot_ofs[IDX_BATT_VOLT] = cell_ofs;
  assign slot_ofs[IDX_SYS_VOLT]  = cell_ofs;

  for (genvar g = 0; g < NUM_RESULTS; g++)
  begin : g_scale
    result_scaler u_scaler (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .code     (result_ff[g]),
      .lsb      (slot_lsb[g]),
      .offset   (slot_ofs[g]),
      .value_ff (eng_value[g])
    );
  end

  // Checks
  AST_BUF_LOWPWR: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R13]
    low_power_mode |=> !batt_current_buffer_en)
    else $error("battery current buffer on in low power mode");

  AST_PMON_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R16]
    (low_power_mode || opt_high_ff.power_monitor_config == PMON_OFF) |=> !power_monitor_en)
    else $error("power monitor enabled while it must be off");

  AST_PMON_ON: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
    (!low_power_mode && opt_high_ff.power_monitor_config == PMON_BUS_BATT)
      |=> power_monitor_en && power_monitor_config == PMON_BUS_BATT)
    else $error("power monitor not enabled for bus plus battery");

  AST_RO_RESULT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R22]
    (wr_strobe && !conv_valid) |=> result_ff[IDX_BUS_VOLT] == $past(result_ff[IDX_BUS_VOLT]))
    else $error("serial write changed a result byte");

  AST_DSCH_SAT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    (conv_valid && conv_sample.dsch_curr > CURR_CODE_MAX) |=> result_ff[IDX_DSCH_CURR] == 8'h7F)
    else $error("discharge result not saturated");

  AST_CHG_BIT7: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    rd_ptr == REG_CHG_CURR |-> !rd_byte[7])
    else $error("charge result bit 7 set");

  AST_LIMIT_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R20]
    rd_ptr == REG_LIMIT_LOW |-> rd_byte == 8'h00)
    else $error("reserved byte reads non-zero");

  AST_CMPREF_WR: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R21]
    (wr_strobe && ptr_ff == REG_OPT_LOW) |=> comparator_reference_select == $past(shift_ff[7]))
    else $error("comparator reference not updated by write");

  AST_POWER_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    (!monitor_range_select)[*3] |-> eng_value[IDX_SYS_POWER] <= 16'd2040)
    else $error("power result above low range full scale");

  AST_BATT_FLOOR: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R10]
    (!five_cell)[*3] |-> eng_value[IDX_BATT_VOLT] >= 16'd2880
                         && eng_value[IDX_BATT_VOLT] <= 16'd19200)
    else $error("battery result outside one to four cell span");

  AST_ADDR_ACK: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
    (state_ff == ST_ADDR && byte_done_ff && scl_fall && addr_match && !stop_seen && !start_seen)
      |=> sda_oe)
    else $error("no acknowledge for own address");

  CVR_OPT_WRITE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    wr_strobe && ptr_ff == REG_OPT_HIGH);
  CVR_BUS_READ: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_ff == ST_RDATA_ACK && ptr_ff == REG_BUS_VOLT);
  CVR_SATURATE: cover property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && conv_sample.dsch_curr > CURR_CODE_MAX);

endmodule : charger_monitor_regs

// ---- dv/serial_host_model.sv ----
// Purpose: Two-wire host that reaches the monitor bank
// Assumes: Data line has a pull-up, so released data reads high
// Notes:   Clock high phases last at least 5 sys_clk and low phases at least 7, above the 4 the port needs
`timescale 1ns/1ps
module serial_host_model
(
  // Clock
  input  wire logic sys_clk,
  // Bus
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  // Also serves as repeated start, since it first releases data
  task automatic start_cond();
    sda_low = 1'b0;
    step(5);
    scl = 1'b1;
    step(5);
    sda_low = 1'b1;
    step(5);
    scl = 1'b0;
    step(5);
  endtask : start_cond
  task automatic stop_cond();
    sda_low = 1'b1;
    step(5);
    scl = 1'b1;
    step(5);
    sda_low = 1'b0;
    step(5);
  endtask : stop_cond
  task automatic bit_xfer(input logic b, output logic r);
    sda_low = ~b;
    step(5);
    scl = 1'b1;
    step(3);
    r = sda_line;
    step(2);
    scl = 1'b0;
    step(2);
  endtask : bit_xfer
  task automatic byte_xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                           output logic ack);
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], q[i]);
    bit_xfer(last, ack);
  endtask : byte_xfer
endmodule : serial_host_model

// ---- dv/testbench.sv ----
// Purpose: Self-checking bench for the monitor result bank
// Assumes: Host model drives the serial port
// Notes:   Rows hold raw codes beside the bytes they should read back
`timescale 1ns/1ps
module testbench
  import charger_monitor_pkg::*;
;
  localparam logic [6:0] DEV = 7'h2A;
  logic sys_clk, rst_n, conv_valid, monitor_range_select, five_cell;
  logic low_power_mode, adapter_present, sda_out, sda_oe, ack;
  logic batt_current_buffer_en, lowpower_hot_signal_en, power_monitor_en, power_monitor_gain;
  logic input_sense_select, charge_sense_select, comparator_reference_select;
  logic [1:0] power_monitor_config;
  logic [7:0] option_low, rd, q;
  logic [NUM_RESULTS-1:0][15:0] eng_value;
  monitor_sample_t conv_sample;
  wire scl, sda_low;
  wire sda_line = (sda_low | sda_oe) ? 1'b0 : 1'b1;
  int bad_count, samples_checked, cycles;
  logic [7:0] row_code [8] = '{8'h10, 8'hFF, 8'hFF, 8'h85, 8'h20, 8'hFF, 8'h05, 8'hFF};
  logic [7:0] row_byte [8] = '{8'h10, 8'hFF, 8'h7F, 8'h7F, 8'h20, 8'hFF, 8'h05, 8'hFF};
  serial_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  charger_monitor_regs #(.DEV_ADDR(DEV)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .conv_valid(conv_valid),
    .conv_sample(conv_sample), .monitor_range_select(monitor_range_select),
    .five_cell(five_cell), .low_power_mode(low_power_mode), .adapter_present(adapter_present),
    .batt_current_buffer_en(batt_current_buffer_en), .power_monitor_en(power_monitor_en),
    .lowpower_hot_signal_en(lowpower_hot_signal_en), .power_monitor_config(power_monitor_config),
    .power_monitor_gain(power_monitor_gain), .input_sense_select(input_sense_select),
    .charge_sense_select(charge_sense_select), .option_low(option_low), .eng_value(eng_value),
    .comparator_reference_select(comparator_reference_select));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // About 30 transfers of at most some 600 cycles each fit well under this ceiling
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    host.start_cond();
    host.byte_xfer({DEV, 1'b0}, 1'b1, q, ack);
    check(ack, 0);
    host.byte_xfer(a, 1'b1, q, ack);
    host.byte_xfer(d, 1'b1, q, ack);
    host.stop_cond();
    tick(2);
  endtask : reg_write
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    host.start_cond();
    host.byte_xfer({DEV, 1'b0}, 1'b1, q, ack);
    host.byte_xfer(a, 1'b1, q, ack);
    host.start_cond();
    host.byte_xfer({DEV, 1'b1}, 1'b1, q, ack);
    host.byte_xfer(8'hFF, 1'b0, d, ack);
    host.byte_xfer(8'hFF, 1'b1, q, ack);
    host.stop_cond();
  endtask : reg_read
  function automatic logic [15:0] expect_val(int i, logic [7:0] c, logic hi);
    logic [9:0] w [8];
    w = '{hi ? 12 : 8, 96, hi ? 512 : 256, hi ? 128 : 64, hi ? 12 : 8, hi ? 100 : 50, 64, 64};
    return (i >= 6 ? (hi ? 16'd2880 : 16'd8160) : 16'd0) + c * w[i];
  endfunction : expect_val
  // High selects: 12 mV range and four cells, expecting 5 milliohm sense weights from the option byte; low selects the opposite
  task automatic run_rows(input logic hi);
    monitor_range_select = hi;
    five_cell = ~hi;
    for (int i = 0; i < 8; i++) conv_sample[i*8 +: 8] = row_code[i];
    conv_valid = 1'b1;
    tick(1);
    conv_valid = 1'b0;
    tick(3);
    for (int i = 0; i < 8; i++)
    begin
      reg_read(8'h26 + i[7:0], rd);
      check(rd, row_byte[i]);
      check(q, i < 7 ? row_byte[i+1] : 8'h00);
      check(eng_value[i], expect_val(i, row_byte[i], hi));
    end
    $display("rows done, high selects %0d", hi);
  endtask : run_rows
  initial
  begin
    rst_n = 1'b0;
    {conv_valid, monitor_range_select, five_cell, low_power_mode, adapter_present} = '0;
    conv_sample = '0;
    tick(10);
    rst_n = 1'b1;
    tick(2);
    reg_read(8'h31, rd);
    check(rd, 8'h3F);
    reg_read(8'h30, rd);
    check(rd, 8'h00);
    reg_read(8'h24, rd);
    check(rd, 8'h00);
    check({power_monitor_config, input_sense_select, charge_sense_select, power_monitor_gain},
          5'b11111);
    $display("reset test done");
    run_rows(1'b1);
    reg_write(8'h27, 8'h00);
    reg_read(8'h27, rd);
    check(rd, 8'hFF);
    for (int c = 0; c < 4; c++)
    begin
      reg_write(8'h31, {2'b00, c[1:0], 4'h0});
      check({power_monitor_en, power_monitor_config}, {c < 2, c[1:0]});
    end
    run_rows(1'b0);
    reg_write(8'h31, 8'hC0);
    check({batt_current_buffer_en, lowpower_hot_signal_en, power_monitor_en}, 3'b111);
    low_power_mode = 1'b1;
    adapter_present = 1'b1;
    tick(2);
    check({batt_current_buffer_en, lowpower_hot_signal_en, power_monitor_en}, 3'b000);
    reg_read(8'h31, rd);
    check(rd, 8'hC0);
    reg_write(8'h30, 8'h80);
    check({sda_out, comparator_reference_select, option_low}, 10'h180);
    host.start_cond();
    host.byte_xfer({DEV ^ 7'h01, 1'b0}, 1'b1, q, ack);
    check(ack, 1);
    host.stop_cond();
    $display("option and refusal tests done");
    finish_test();
  end
endmodule : testbench
